//--- common/ops_link_regs.svh
// Constants of the one-pin programming link: fields, codes, times and cycle counts
`ifndef OPS_LINK_REGS_SVH
`define OPS_LINK_REGS_SVH

// Clock rate
`define OPS_CLK_MHZ         20

// Times in nanoseconds
`define OPS_T_BIT_NS        40000
`define OPS_T_W0_NS         10000
`define OPS_T_W1_NS         30000
`define OPS_T_TKO_SLV_NS    5000
`define OPS_T_TO_NS         40000000
`define OPS_T_CMD_ENT_NS    20000000

// Cycle counts: least times round up, longest times round down
`define OPS_BIT_CYC         ((`OPS_T_BIT_NS * `OPS_CLK_MHZ) / 1000)
`define OPS_W0_CYC          ((`OPS_T_W0_NS * `OPS_CLK_MHZ + 999) / 1000)
`define OPS_W1_CYC          ((`OPS_T_W1_NS * `OPS_CLK_MHZ + 999) / 1000)
`define OPS_THR_CYC         ((`OPS_W0_CYC + `OPS_W1_CYC) / 2)
`define OPS_REL_CYC         ((`OPS_BIT_CYC * 3) / 4)
`define OPS_TKO_CYC         ((`OPS_T_TKO_SLV_NS * `OPS_CLK_MHZ + 999) / 1000)
`define OPS_TO_CYC          ((`OPS_T_TO_NS * `OPS_CLK_MHZ) / 1000)
`define OPS_ENT_CYC         ((`OPS_T_CMD_ENT_NS * `OPS_CLK_MHZ) / 1000)

// Command byte layout
`define OPS_CMD_REGION_MSB  7
`define OPS_CMD_REGION_LSB  5
`define OPS_CMD_ADDR_MSB    4
`define OPS_CMD_ADDR_LSB    1
`define OPS_CMD_DIR_BIT     0
`define OPS_DIR_WRITE       1'h0
`define OPS_REGION_NVM      3'h0
`define OPS_REGION_REG      3'h4

// Frame sizes
`define OPS_CMD_BITS        8
`define OPS_WORD_BITS       16

// Command mode entry
`define OPS_SIG_CMD         8'h94
`define OPS_SIG_VALUE       16'h16F4

// Checksum
`define OPS_CRC_INIT        8'hFF
`define OPS_CRC_POLY        9'h107
`define OPS_CRC_TOP_BIT     8

`endif

//--- common/ops_link_pkg.sv
// Types of the one-pin programming link slave
package ops_link_pkg;

  typedef logic [15:0] ops_word_t;
  typedef logic [7:0]  ops_crc_t;
  typedef logic [3:0]  ops_addr_t;
  typedef logic [2:0]  ops_region_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_STOP = 6'h04,
    ST_TKO  = 6'h08,
    ST_TX   = 6'h10,
    ST_DROP = 6'h20
  } ops_state_t;

endpackage : ops_link_pkg

//--- rtl/ops_link_slave.sv
// One-pin programming link slave: bit decode, framing, takeover, entry and checksum
`timescale 1ns/100ps
`include "ops_link_regs.svh"

module ops_link_slave #(
  parameter int TO_CYC  = `OPS_TO_CYC,
  parameter int ENT_CYC = `OPS_ENT_CYC
) (
  // Clock, reset and enable
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  // Shared pin, split into level, drive and enable (enable low while driving)
  input  wire logic               i_link_pin,
  output logic                    o_link_out,
  output logic                    o_link_oe_n,
  // Mode
  input  wire logic               i_diag_mode,
  output logic                    o_cmd_mode,
  output logic                    o_analog_en,
  // Access to memory and registers
  output logic                    o_wr_stb,
  output logic                    o_rd_stb,
  output ops_link_pkg::ops_region_t o_acc_region,
  output ops_link_pkg::ops_addr_t o_acc_addr,
  output ops_link_pkg::ops_word_t o_wr_data,
  input  wire ops_link_pkg::ops_word_t i_rd_data,
  // Checksum engine
  input  wire logic               i_crc_clear,
  input  wire logic               i_crc_valid,
  input  wire ops_link_pkg::ops_word_t i_crc_word,
  output ops_link_pkg::ops_crc_t  o_crc
);
  import ops_link_pkg::*;

  localparam int             CW       = 20;
  localparam logic [11:0]    BIT_CYC  = 12'(`OPS_BIT_CYC);
  localparam logic [11:0]    W0_CYC   = 12'(`OPS_W0_CYC);
  localparam logic [11:0]    W1_CYC   = 12'(`OPS_W1_CYC);
  localparam logic [11:0]    THR_CYC  = 12'(`OPS_THR_CYC);
  localparam logic [11:0]    REL_CYC  = 12'(`OPS_REL_CYC);
  localparam logic [11:0]    TKO_CYC  = 12'(`OPS_TKO_CYC);
  localparam logic [CW-1:0]  TO_LAST  = CW'(TO_CYC - 1);
  localparam logic [CW-1:0]  ENT_END  = CW'(ENT_CYC);
  localparam logic [4:0]     CMD_LAST = 5'(`OPS_CMD_BITS - 1);
  localparam logic [4:0]     HND_LAST = 5'(`OPS_CMD_BITS);
  localparam logic [4:0]     WR_LAST  = 5'(`OPS_CMD_BITS + 2 * 8 - 1);
  localparam logic [4:0]     TX_HAND  = 5'(`OPS_WORD_BITS);

  //////////////////////////////////////////////////////////////////////////////
  // Checksum step over one word, MSB first, fed in at the low end
  function automatic ops_crc_t crc_word(input ops_crc_t crc, input ops_word_t data);
    logic [8:0] acc;
    acc = {1'b0, crc};
    for (int i = 15; i >= 0; i--)
    begin
      acc = {acc[7:0], data[i]};
      if (acc[`OPS_CRC_TOP_BIT])
      begin
        acc = acc ^ `OPS_CRC_POLY;
      end
    end
    return acc[7:0];
  endfunction : crc_word

  //////////////////////////////////////////////////////////////////////////////
  ops_state_t     state_ff;
  logic           link_s1_ff;
  logic           link_s2_ff;
  logic           link_d_ff;
  logic [11:0]    high_cnt_ff;
  logic [CW-1:0]  to_cnt_ff;
  logic [CW-1:0]  ent_cnt_ff;
  logic           cmd_mode_ff;
  logic [4:0]     bit_cnt_ff;
  logic [23:0]    shift_ff;
  logic [7:0]     cmd_ff;
  logic [11:0]    tmr_ff;
  logic [4:0]     tx_idx_ff;
  ops_word_t      tx_word_ff;
  ops_crc_t       crc_ff;
  logic           rise;
  logic           fall;
  logic           rx_bit;
  logic           timeout;
  logic           entry_ok;
  logic           driving;
  logic           tx_level;
  logic [7:0]     nxt_cmd;
  logic           cmd_allowed;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; the first stage feeds only the second
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      link_s1_ff <= 1'b0;
      link_s2_ff <= 1'b0;
      link_d_ff  <= 1'b0;
    end
    else if (i_ce)
    begin
      link_s1_ff <= i_link_pin;
      link_s2_ff <= link_s1_ff;
      link_d_ff  <= link_s2_ff;
    end
  end

  // Edges of the synchronised line
  assign rise = link_s2_ff & ~link_d_ff;
  assign fall = ~link_s2_ff & link_d_ff;

  // High pulse width, restarted at each rising edge, saturating
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      high_cnt_ff <= 12'h000;
    else if (i_ce)
    begin
      if (rise)
        high_cnt_ff <= 12'h001;
      else if (link_s2_ff && high_cnt_ff != 12'hFFF)
        high_cnt_ff <= high_cnt_ff + 12'h001;
    end
  end

  // Long pulse reads as one, short as zero
  assign rx_bit = (high_cnt_ff >= THR_CYC);

  // Time since the last rising edge; our own drive phases do not count
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      to_cnt_ff <= '0;
    else if (i_ce)
    begin
      if (rise || driving || state_ff == ST_IDLE)
        to_cnt_ff <= '0;
      else if (!timeout)
        to_cnt_ff <= to_cnt_ff + CW'(1);
    end
  end

  assign timeout = (to_cnt_ff == TO_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // Entry slot after reset; the slot counter stops once it has run out
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      ent_cnt_ff <= '0;
    else if (i_ce && ent_cnt_ff != ENT_END)
      ent_cnt_ff <= ent_cnt_ff + CW'(1);
  end

  // Diagnostic mode keeps the door open after the slot closes
  assign entry_ok = (ent_cnt_ff != ENT_END) | i_diag_mode;

  // Command field checks at the eighth bit
  assign nxt_cmd = {shift_ff[6:0], rx_bit};
  always_comb
  begin
    if (nxt_cmd[`OPS_CMD_DIR_BIT] == `OPS_DIR_WRITE)
      cmd_allowed = cmd_mode_ff | (entry_ok & (nxt_cmd == `OPS_SIG_CMD));
    else
      cmd_allowed = cmd_mode_ff;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      shift_ff   <= 24'h000000;
      cmd_ff     <= 8'h00;
      tmr_ff     <= 12'h000;
      tx_idx_ff  <= 5'h00;
      tx_word_ff <= 16'h0000;
    end
    else if (i_ce)
    begin
      case (state_ff)
        ST_IDLE:
        begin
          // A rising edge after low opens a frame
          if (rise)
          begin
            state_ff   <= ST_RX;
            bit_cnt_ff <= 5'h00;
          end
        end
        ST_RX:
        begin
          if (timeout)
            state_ff <= ST_IDLE;
          else if (fall)
          begin
            shift_ff   <= {shift_ff[22:0], rx_bit};
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == CMD_LAST)
            begin
              cmd_ff <= nxt_cmd;
              if (!cmd_allowed)
                state_ff <= ST_DROP;
            end
            else if (bit_cnt_ff == HND_LAST && cmd_ff[`OPS_CMD_DIR_BIT] != `OPS_DIR_WRITE)
            begin
              // Handover bit must read as zero before we take the line
              state_ff <= rx_bit ? ST_DROP : ST_TKO;
              // Time from the bit's rise, so our low outlasts the master's release
              tmr_ff   <= high_cnt_ff;
            end
            else if (bit_cnt_ff == WR_LAST)
              state_ff <= ST_STOP;
          end
        end
        ST_TKO:
        begin
          // Overlap the master's low until its release, then hold it alone
          if (tmr_ff == REL_CYC + TKO_CYC - 12'h001)
          begin
            state_ff   <= ST_TX;
            tmr_ff     <= 12'h000;
            tx_idx_ff  <= 5'h00;
            tx_word_ff <= i_rd_data;
          end
          else
            tmr_ff <= tmr_ff + 12'h001;
        end
        ST_TX:
        begin
          if (tx_idx_ff == TX_HAND && tmr_ff == REL_CYC - 12'h001)
            state_ff <= ST_STOP;
          else if (tmr_ff == BIT_CYC - 12'h001)
          begin
            tmr_ff    <= 12'h000;
            tx_idx_ff <= tx_idx_ff + 5'h01;
          end
          else
            tmr_ff <= tmr_ff + 12'h001;
        end
        ST_STOP:
        begin
          // Pull-up or master gives the closing edge; pull-down times out
          if (rise || timeout)
            state_ff <= ST_IDLE;
        end
        ST_DROP:
        begin
          // Refused frames are sat out until the line goes quiet
          if (timeout)
            state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive: low during takeover, pulse-width coded bits while sending
  assign tx_level = (tx_idx_ff == TX_HAND) ? 1'b0 : tx_word_ff[4'(15 - tx_idx_ff)];
  assign driving  = (state_ff == ST_TKO) | (state_ff == ST_TX);
  assign o_link_oe_n = ~driving;
  assign o_link_out  = (state_ff == ST_TX) &&
                       (tmr_ff < (tx_level ? W1_CYC : W0_CYC));

  //////////////////////////////////////////////////////////////////////////////
  // Command mode latch; only a reset clears it
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cmd_mode_ff <= 1'b0;
    else if (i_ce && state_ff == ST_STOP && rise && cmd_ff == `OPS_SIG_CMD &&
             shift_ff[15:0] == `OPS_SIG_VALUE && entry_ok)
      cmd_mode_ff <= 1'b1;
  end

  // Analog output stays on until command mode is entered
  assign o_cmd_mode  = cmd_mode_ff;
  assign o_analog_en = ~cmd_mode_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Access strobes: write on the closing edge, read when the command lands
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_wr_stb     <= 1'b0;
      o_rd_stb     <= 1'b0;
      o_acc_region <= 3'h0;
      o_acc_addr   <= 4'h0;
      o_wr_data    <= 16'h0000;
    end
    else if (i_ce)
    begin
      o_wr_stb <= cmd_mode_ff && state_ff == ST_STOP && rise &&
                  cmd_ff[`OPS_CMD_DIR_BIT] == `OPS_DIR_WRITE;
      o_rd_stb <= state_ff == ST_RX && fall && bit_cnt_ff == CMD_LAST &&
                  cmd_allowed && nxt_cmd[`OPS_CMD_DIR_BIT] != `OPS_DIR_WRITE;
      if (state_ff == ST_RX && fall && bit_cnt_ff == CMD_LAST)
      begin
        o_acc_region <= nxt_cmd[`OPS_CMD_REGION_MSB:`OPS_CMD_REGION_LSB];
        o_acc_addr   <= nxt_cmd[`OPS_CMD_ADDR_MSB:`OPS_CMD_ADDR_LSB];
      end
      if (state_ff == ST_STOP && rise)
        o_wr_data <= shift_ff[15:0];
    end
  end

  // Checksum accumulator, cleared to the start value
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      crc_ff <= `OPS_CRC_INIT;
    else if (i_ce)
    begin
      if (i_crc_clear)
        crc_ff <= `OPS_CRC_INIT;
      else if (i_crc_valid)
        crc_ff <= crc_word(crc_ff, i_crc_word);
    end
  end

  assign o_crc = crc_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_takeover_begins;
    i_ce && state_ff == ST_RX && fall && bit_cnt_ff == HND_LAST && !rx_bit &&
    cmd_ff[`OPS_CMD_DIR_BIT] != `OPS_DIR_WRITE;
  endsequence

  sequence s_line_held_low;
    (!o_link_oe_n && !o_link_out);
  endsequence

  AST_NO_DRIVE_OUTSIDE_CMD: assert property (!cmd_mode_ff |-> o_link_oe_n)
    else $error("pin driven outside command mode");
  AST_ANALOG_OFF: assert property (cmd_mode_ff |-> !o_analog_en && o_cmd_mode)
    else $error("analog output on in command mode");
  AST_CMD_STICKY: assert property (cmd_mode_ff |=> cmd_mode_ff)
    else $error("command mode left without reset");
  AST_ENTRY_SLOT: assert property ($rose(cmd_mode_ff) |-> $past(entry_ok))
    else $error("command mode entered outside slot");
  AST_TAKEOVER_LOW: assert property (s_takeover_begins |=> s_line_held_low [*4])
    else $error("takeover did not drive low");
  AST_TIMEOUT_IDLE: assert property (
    i_ce && timeout && (state_ff == ST_RX || state_ff == ST_DROP) |=> state_ff == ST_IDLE)
    else $error("timeout did not return to idle");
  AST_CRC_START: assert property (i_ce && i_crc_clear |=> o_crc == 8'hFF)
    else $error("checksum not reset to start value");
  AST_WRITE_DIR: assert property (o_wr_stb |-> o_acc_region == $past(cmd_ff[7:5]) &&
                                  $past(cmd_ff[0]) == 1'b0)
    else $error("write strobe without write command");
  AST_HANDOVER_RELEASE: assert property (
    i_ce && state_ff == ST_TX && tx_idx_ff == TX_HAND && tmr_ff == REL_CYC - 12'h001
    |-> !o_link_out ##1 o_link_oe_n)
    else $error("device handover not released at three quarters");

endmodule : ops_link_slave

//--- verif/ops_prog_master.sv
// Programming master model that drives the shared pin from the far side
`timescale 1ns/100ps
`include "ops_link_regs.svh"

module ops_prog_master (
  // Clock and sensed line level
  input  wire logic i_clk,
  input  wire logic i_line,
  // Pin drive, enable low while driving
  output logic      o_out,
  output logic      o_oe_n
);
  ////////////////////////////////////////////////////////////
  // Hold the line low from time zero so no stray start is seen
  initial
  begin
    o_out  = 1'b0;
    o_oe_n = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask : hold

  // Low level ahead of the first rising edge
  task automatic start();
    o_oe_n = 1'b0;
    o_out  = 1'b0;
    hold(200);
  endtask : start

  // High width carries the value; optional release at three quarters
  task automatic send_bit(input logic b, input logic rel);
    int w;
    w      = b ? `OPS_W1_CYC : `OPS_W0_CYC;
    o_out  = 1'b1;
    hold(w);
    o_out  = 1'b0;
    hold(`OPS_REL_CYC - w);
    o_oe_n = rel;
    hold(`OPS_BIT_CYC - `OPS_REL_CYC);
  endtask : send_bit

  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      send_bit(v[i], 1'b0);
  endtask : send_byte

  task automatic send_word(input logic [15:0] v);
    send_byte(v[15:8]);
    send_byte(v[7:0]);
  endtask : send_word

  // Rising edge after the low level closes the frame
  task automatic stop();
    o_oe_n = 1'b0;
    o_out  = 1'b1;
    hold(200);
    o_out  = 1'b0;
    hold(100);
  endtask : stop

  // Count the device's 17 falls, then drive low across its release
  task automatic take_back();
    int   falls;
    logic prev;
    falls = 0;
    prev  = i_line;
    for (int i = 0; i < 40000 && falls < 17; i++)
    begin
      hold(1);
      if (prev === 1'b1 && i_line === 1'b0)
        falls++;
      prev = i_line;
    end
    o_oe_n = 1'b0;
    hold(`OPS_REL_CYC - `OPS_W0_CYC + 200);
    stop();
  endtask : take_back
endmodule : ops_prog_master

//--- verif/testbench.sv
// Bench: checksum engine, refused traffic, command mode entry, a write and a read frame
`timescale 1ns/100ps
`include "ops_link_regs.svh"

module testbench;
  import ops_link_pkg::*;

  localparam int          TO_CYC   = 3000;
  localparam int          ENT_CYC  = 5000;
  localparam logic [15:0] DOC_W[8] = '{16'h0000, 16'hFFC1, 16'h0400, 16'h0100,
                                       16'h1300, 16'h0000, 16'h0000, 16'h0000};

  logic        clk, rst_n, ce, diag, link_pin, dev_out, dev_oe_n, m_out, m_oe_n;
  logic        cmd_mode, analog_en, wr_stb, rd_stb, crc_clear, crc_valid, sent, prev_out;
  ops_region_t acc_region;
  ops_addr_t   acc_addr, addr, waddr;
  ops_word_t   wr_data, rd_data, crc_word, wdata;
  ops_crc_t    crc, e;
  int          n_mismatch, checked, cyc, drv_cyc, hi_cnt, tko_cnt, clash;
  logic [15:0] exp_q[$];
  string       nm_q[$];

  ////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Clash shows as unknown; a released line falls to the pull-down
  assign link_pin = (!dev_oe_n && !m_oe_n && dev_out !== m_out) ? 1'bx :
                    !dev_oe_n ? dev_out : !m_oe_n ? m_out : 1'b0;

  ops_link_slave #(.TO_CYC(TO_CYC), .ENT_CYC(ENT_CYC)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_link_pin(link_pin),
    .o_link_out(dev_out), .o_link_oe_n(dev_oe_n), .i_diag_mode(diag),
    .o_cmd_mode(cmd_mode), .o_analog_en(analog_en), .o_wr_stb(wr_stb),
    .o_rd_stb(rd_stb), .o_acc_region(acc_region), .o_acc_addr(acc_addr),
    .o_wr_data(wr_data), .i_rd_data(rd_data), .i_crc_clear(crc_clear),
    .i_crc_valid(crc_valid), .i_crc_word(crc_word), .o_crc(crc));

  ops_prog_master m_u (.i_clk(clk), .i_line(link_pin), .o_out(m_out), .o_oe_n(m_oe_n));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic note(input string nm, input logic [15:0] v);
    nm_q.push_back(nm);
    exp_q.push_back(v);
  endtask : note

  // A result with no note waiting is itself a mismatch
  task automatic take(input logic [15:0] seen);
    if (exp_q.size() == 0)
      chk("unexpected", seen, ~seen);
    else
      chk(nm_q.pop_front(), seen, exp_q.pop_front());
  endtask : take

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Bitwise reference, one data bit in at the low end per step
  function automatic logic [7:0] crc_ref(input logic [7:0] c, input logic [15:0] w);
    logic [8:0] a;
    a = {1'b0, c};
    for (int i = 15; i >= 0; i--)
    begin
      a = {a[7:0], w[i]};
      if (a[8])
        a = a ^ `OPS_CRC_POLY;
    end
    return a[7:0];
  endfunction : crc_ref

  // Valid is left high so back-to-back folds never retoggle it
  task automatic fold(input logic [15:0] w);
    crc_word  = w;
    crc_valid = 1'b1;
    @(negedge clk);
  endtask : fold

  ////////////////////////////////////////////////////////////
  // Watch strobes and device-sent bits against the oldest note
  always @(negedge clk)
  begin
    if (rd_stb === 1'b1)
      take({9'h0, acc_region, acc_addr});
    if (wr_stb === 1'b1)
    begin
      take({9'h0, acc_region, acc_addr});
      take(wr_data);
    end
    if (dev_oe_n === 1'b0)
    begin
      drv_cyc++;
      if (dev_out === 1'b1)
        hi_cnt++;
      else if (sent !== 1'b1)
        tko_cnt++;
      if (prev_out === 1'b1 && dev_out === 1'b0)
      begin
        take({15'h0, hi_cnt >= `OPS_THR_CYC});
        hi_cnt = 0;
      end
      if (dev_out === 1'b1)
        sent = 1'b1;
    end
    if (!dev_oe_n && !m_oe_n && dev_out !== m_out)
      clash++;
    prev_out = dev_out;
  end

  // Hang guard, sized past the five link frames (about 81000 cycles)
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    rst_n     = 1'b0;
    ce        = 1'b1;
    diag      = 1'b0;
    rd_data   = 16'h0000;
    crc_clear = 1'b0;
    crc_valid = 1'b0;
    crc_word  = 16'h0000;
    void'($urandom(69542));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk("crc_reset", {8'h00, crc}, 16'h00FF);
    chk("analog_reset", {15'h0, analog_en}, 16'h0001);
    // Known word set, then its self-check with the result folded back
    for (int k = 0; k < 8; k++)
      fold(DOC_W[k]);
    crc_valid = 1'b0;
    chk("crc_set", {8'h00, crc}, 16'h00A9);
    crc_clear = 1'b1;
    @(negedge clk);
    crc_clear = 1'b0;
    for (int k = 0; k < 8; k++)
      fold(DOC_W[k] | (k == 7 ? 16'h00A9 : 16'h0000));
    chk("crc_check", {8'h00, crc}, 16'h0000);
    crc_clear = 1'b1;
    fold(16'h5A5A);
    crc_clear = 1'b0;
    crc_valid = 1'b0;
    chk("crc_clear_first", {8'h00, crc}, 16'h00FF);
    e = 8'hFF;
    for (int k = 0; k < 4; k++)
    begin
      crc_word = 16'($urandom);
      e = crc_ref(e, crc_word);
      fold(crc_word);
    end
    crc_valid = 1'b0;
    chk("crc_random", {8'h00, crc}, {8'h00, e});
    // Enable low freezes the checksum even with a word offered
    ce = 1'b0;
    fold(16'h1234);
    ce = 1'b1;
    crc_valid = 1'b0;
    chk("crc_frozen", {8'h00, crc}, {8'h00, e});
    // Read before entry is sat out; then the line must recover
    m_u.start();
    m_u.send_byte({`OPS_REGION_REG, 4'h1, 1'b1});
    m_u.hold(TO_CYC + 500);
    chk("refused_drive", 16'(drv_cyc), 16'h0000);
    chk("mode_refused", {15'h0, cmd_mode}, 16'h0000);
    // Slot has closed: an entry command without diagnostic mode is dropped
    m_u.start();
    m_u.send_byte(`OPS_SIG_CMD);
    m_u.hold(TO_CYC + 500);
    chk("late_entry_drive", 16'(drv_cyc), 16'h0000);
    chk("late_entry_mode", {15'h0, cmd_mode}, 16'h0000);
    // Diagnostic mode reopens the door; analog kept on while it is sent
    diag = 1'b1;
    m_u.start();
    m_u.send_byte(`OPS_SIG_CMD);
    m_u.send_word(`OPS_SIG_VALUE);
    chk("analog_entry", {15'h0, analog_en}, 16'h0001);
    m_u.stop();
    m_u.hold(20);
    chk("mode_entered", {15'h0, cmd_mode}, 16'h0001);
    chk("analog_cmd", {15'h0, analog_en}, 16'h0000);
    // Register write of a random word to a random register address
    waddr = 4'($urandom);
    wdata = 16'($urandom);
    note("wr_target", {9'h0, `OPS_REGION_REG, waddr});
    note("wr_word", wdata);
    m_u.start();
    m_u.send_byte({`OPS_REGION_REG, waddr, `OPS_DIR_WRITE});
    m_u.send_word(wdata);
    m_u.stop();
    m_u.hold(20);
    chk("wr_pending", 16'(exp_q.size()), 16'h0000);
    // Register read with handover both ways
    addr    = 4'($urandom);
    rd_data = 16'($urandom);
    drv_cyc = 0;
    tko_cnt = 0;
    hi_cnt  = 0;
    clash   = 0;
    sent    = 1'b0;
    note("rd_target", {9'h0, `OPS_REGION_REG, addr});
    for (int k = 15; k >= 0; k--)
      note("rd_bit", {15'h0, rd_data[k]});
    note("rd_handover", 16'h0000);
    m_u.start();
    m_u.send_byte({`OPS_REGION_REG, addr, 1'b1});
    m_u.send_bit(1'b0, 1'b1);
    m_u.take_back();
    m_u.hold(50);
    chk("rd_pending", 16'(exp_q.size()), 16'h0000);
    // Device low spans the master's release plus its own takeover time
    chk("tko_low", 16'(tko_cnt),
        16'(`OPS_REL_CYC - `OPS_W0_CYC + `OPS_TKO_CYC));
    chk("drive_len", 16'(drv_cyc), 16'(`OPS_REL_CYC - `OPS_W0_CYC + `OPS_TKO_CYC +
        16 * `OPS_BIT_CYC + `OPS_REL_CYC));
    chk("clash", 16'(clash), 16'h0000);
    chk("mode_kept", {15'h0, cmd_mode}, 16'h0001);
    close_out();
  end
endmodule : testbench
